// file: rtl/ocot_defines.svh
`ifndef OCOT_DEFINES_SVH
`define OCOT_DEFINES_SVH
`define OCOT_CMD_CUR_WARN 8'h4a
`define OCOT_CMD_TEMP_FAULT 8'h4f
`define OCOT_CMD_TEMP_ACT 8'h50
`define OCOT_EXP_MSB 15
`define OCOT_EXP_LSB 11
`define OCOT_MANT_MSB 10
`define OCOT_ACT_SEL_MSB 7
`define OCOT_ACT_SEL_LSB 6
`define OCOT_POLICY_MSB 5
`define OCOT_POLICY_LSB 3
`define OCOT_DELAY_MSB 2
`define OCOT_DELAY_LSB 0
`define OCOT_CUR_EXP_RST 5'b11110
`define OCOT_TEMP_EXP_RST 5'b00000
`define OCOT_CUR_WARN_RST 16'hf3e0
`define OCOT_TEMP_FAULT_RST 16'h007d
`define OCOT_TEMP_ACT_RST 8'h80
`define OCOT_ACT_IGNORE 2'b00
`define OCOT_ACT_DELAYED 2'b01
`define OCOT_ACT_IMMEDIATE 2'b10
`define OCOT_ACT_WAIT_COOL 2'b11
`define OCOT_POLICY_FOREVER 3'd7
`define OCOT_PHASES 4
`define OCOT_CUR_FRAC 6
`define OCOT_CUR_STEP_X 128
`define OCOT_CUR_MIN_X 512
`define OCOT_CUR_MAX_X 3968
`define OCOT_TEMP_OFF_Q 1020
`define OCOT_TEMP_HYST_Q 80
`define OCOT_TEMP_NVM_MAX_C 160
`define OCOT_DELAY0_MS 10
`define OCOT_MS_NS 1000000
`define OCOT_CLK_NS 40
`endif

// file: rtl/ocot_pkg.sv
package ocot_pkg;
    typedef enum logic [2:0] {
        ST_RUN,
        ST_DELAY,
        ST_WAIT_COOL,
        ST_HICCUP,
        ST_LATCHED
    } ocot_state_t;
endpackage

// file: rtl/ocot_monitor.sv
`timescale 1ns/10ps
`include "ocot_defines.svh"
// What this block does
// - each phase compares and warns on its own
// - current warning sets status bits, notifies host
// - current limit word: exponent 15:11, resets 11110b
// - out-of-range limit write flagged as unsupported
// - applied phase threshold 8-62 A, round up
// - below 8 A accepted, applied as 8 A
// - restore rounds current limit to 0.25 A
// - temperature limit word: exponent resets 00000b
// - full resolution; restore to 0-160 C
// - 255 C disables programmable temperature fault
// - temperature fault sets status bits, notifies host
// - fault released below warning limit, restart allowed
// - warning above fault: release 20 C below fault
// - action field selects ignore/delay/immediate/wait cool
// - restart policy: latch, 1-6 tries (wait cool: no limit), forever
// - hidden restart attempts while hot still count
// - delay field sets shutdown delay and hiccup
// - warning limit exceeded sets warning, notifies
// - wait-cool clear while hot keeps fault
module ocot_monitor #(
    parameter int MS_CYCLES = `OCOT_MS_NS / `OCOT_CLK_NS
) (
    input wire logic i_clock, // 25 MHz
    input wire logic i_rst_n, // synchronous reset
    input wire logic i_cmd_valid, // command strobe
    input wire logic i_cmd_write, // 1 write, 0 read
    input wire logic [7:0] i_cmd_code, // command code
    input wire logic [15:0] i_cmd_wdata, // write data
    input wire logic i_nvm_restore, // power cycle or store/restore
    input wire logic i_clear_faults, // clear status flags
    input wire logic i_output_enable, // output commanded on
    input wire logic i_startup_ok, // restart reached regulation
    input wire logic [7:0] i_ton_rise_ms, // soft-start time in ms
    input wire logic signed [11:0] i_temp_q, // die temp, 0.25 C
    input wire logic signed [11:0] i_warn_limit_q, // warn limit, 0.25 C
    input wire logic [39:0] i_phase_current_q, // 4 x 10 bits, 0.25 A
    output logic [15:0] o_rdata, // read data
    output logic o_rdata_valid, // read data strobe
    output logic [3:0] o_phase_warning, // per-phase warning
    output logic o_current_warning_flag, // status iout warning
    output logic o_status_byte_nota, // none of the above
    output logic o_status_word_iout, // iout summary
    output logic o_status_byte_temp, // temperature summary
    output logic o_temp_fault_flag, // temperature fault
    output logic o_temp_warning_flag, // temperature warning
    output logic o_unsupported_data, // bad data written
    output logic o_notify, // host alert, level
    output logic [7:0] o_cur_threshold_q, // applied phase limit
    output logic o_shutdown, // power stage off
    output logic o_restart, // restart attempt pulse
    output logic o_latched_off // latched off
);
    logic [15:0] cur_warn_r;
    logic [15:0] temp_fault_r;
    logic [7:0] temp_act_r;
    logic [3:0] phase_warn_r;
    logic temp_fault_r_flag;
    logic temp_warn_r;
    logic bad_data_r;
    logic restart_r;
    logic [15:0] tick_cnt_r;
    logic [11:0] timer_r;
    logic [2:0] attempts_r;
    ocot_pkg::ocot_state_t state_r;
    logic signed [31:0] cur_x;
    logic signed [31:0] wr_cur_x;
    logic signed [31:0] wr_temp_q;
    logic signed [31:0] fault_q;
    logic signed [31:0] temp_q;
    logic signed [31:0] warn_q;
    logic signed [31:0] release_q;
    logic signed [31:0] rest_cur;
    logic signed [31:0] rest_temp;
    logic [31:0] per_x;
    logic [31:0] th_x;
    logic ms_tick;
    logic over_fault;
    logic below_release;
    logic wr_strobe;
    logic [1:0] act_sel;
    logic [2:0] policy;
    logic [2:0] delay_sel;
    logic [11:0] delay_ms;
    logic [11:0] hiccup_ms;
    logic give_up;

    // value of a linear word scaled by 2**f
    function automatic logic signed [31:0] lin_fx(input logic [15:0] w, input int f);
        int sh;
        logic signed [31:0] m;
        sh = int'($signed(w[`OCOT_EXP_MSB:`OCOT_EXP_LSB])) + f;
        m = 32'($signed(w[`OCOT_MANT_MSB:0]));
        if (sh > 16)
            sh = 16;
        if (sh >= 0)
            lin_fx = m <<< sh;
        else
            lin_fx = m >>> (-sh);
    endfunction

    assign wr_strobe = i_cmd_valid && i_cmd_write;
    assign act_sel = temp_act_r[`OCOT_ACT_SEL_MSB:`OCOT_ACT_SEL_LSB];
    assign policy = temp_act_r[`OCOT_POLICY_MSB:`OCOT_POLICY_LSB];
    assign delay_sel = temp_act_r[`OCOT_DELAY_MSB:`OCOT_DELAY_LSB];

    // fine resolution so that rounding up is exact to 1/64 A
    always_comb
    begin
        cur_x = lin_fx(cur_warn_r, `OCOT_CUR_FRAC);
        wr_cur_x = lin_fx(i_cmd_wdata, `OCOT_CUR_FRAC);
        wr_temp_q = lin_fx(i_cmd_wdata, 2);
        fault_q = lin_fx(temp_fault_r, 2);
        rest_cur = (lin_fx(cur_warn_r, 3) + 32'sd1) >>> 1;
        rest_temp = (lin_fx(temp_fault_r, 1) + 32'sd1) >>> 1;
        if (rest_temp < 0)
            rest_temp = 0;
        if (rest_temp > `OCOT_TEMP_NVM_MAX_C)
            rest_temp = `OCOT_TEMP_NVM_MAX_C;
        per_x = 32'(cur_x) / `OCOT_PHASES;
        th_x = ((per_x + `OCOT_CUR_STEP_X - 1) / `OCOT_CUR_STEP_X) * `OCOT_CUR_STEP_X;
        if (per_x <= `OCOT_CUR_MIN_X)
            th_x = `OCOT_CUR_MIN_X;
        if (th_x > `OCOT_CUR_MAX_X)
            th_x = `OCOT_CUR_MAX_X;
    end

    assign temp_q = 32'(i_temp_q);
    assign warn_q = 32'(i_warn_limit_q);
    assign over_fault = (fault_q != `OCOT_TEMP_OFF_Q) && (temp_q > fault_q);
    assign release_q = (warn_q > fault_q) ? fault_q - `OCOT_TEMP_HYST_Q : warn_q;
    assign below_release = temp_q < release_q;

    // limit registers: writes apply at once, no output disable needed
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            cur_warn_r <= `OCOT_CUR_WARN_RST;
            temp_fault_r <= `OCOT_TEMP_FAULT_RST;
            temp_act_r <= `OCOT_TEMP_ACT_RST;
        end
        else if (i_nvm_restore)
        begin
            cur_warn_r <= {`OCOT_CUR_EXP_RST, rest_cur[10:0]};
            temp_fault_r <= {`OCOT_TEMP_EXP_RST, rest_temp[10:0]};
        end
        else if (wr_strobe)
        begin
            case (i_cmd_code)
                `OCOT_CMD_CUR_WARN:
                    if (wr_cur_x >= 0 && wr_cur_x <= `OCOT_CUR_MAX_X * `OCOT_PHASES)
                        cur_warn_r <= i_cmd_wdata;
                `OCOT_CMD_TEMP_FAULT:
                    if (wr_temp_q >= 0 && wr_temp_q <= `OCOT_TEMP_OFF_Q)
                        temp_fault_r <= i_cmd_wdata;
                `OCOT_CMD_TEMP_ACT:
                    temp_act_r <= i_cmd_wdata[7:0];
                default:
                    ;
            endcase
        end
    end

    // unsupported data flag; a new error beats a clear
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
            bad_data_r <= 1'b0;
        else if (wr_strobe && !i_nvm_restore && (
                 (i_cmd_code == `OCOT_CMD_CUR_WARN &&
                  (wr_cur_x < 0 || wr_cur_x > `OCOT_CUR_MAX_X * `OCOT_PHASES)) ||
                 (i_cmd_code == `OCOT_CMD_TEMP_FAULT &&
                  (wr_temp_q < 0 || wr_temp_q > `OCOT_TEMP_OFF_Q))))
            bad_data_r <= 1'b1;
        else if (i_clear_faults)
            bad_data_r <= 1'b0;
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            o_rdata <= 16'h0000;
            o_rdata_valid <= 1'b0;
        end
        else
        begin
            o_rdata_valid <= i_cmd_valid && !i_cmd_write;
            case (i_cmd_code)
                `OCOT_CMD_CUR_WARN:
                    o_rdata <= cur_warn_r;
                `OCOT_CMD_TEMP_FAULT:
                    o_rdata <= temp_fault_r;
                `OCOT_CMD_TEMP_ACT:
                    o_rdata <= {8'h00, temp_act_r};
                default:
                    o_rdata <= 16'h0000;
            endcase
        end
    end

    // one comparator per phase, sticky until cleared
    genvar p;
    generate
        for (p = 0; p < `OCOT_PHASES; p++)
        begin : g_phase
            always_ff @(posedge i_clock)
            begin
                if (!i_rst_n)
                    phase_warn_r[p] <= 1'b0;
                else if ({i_phase_current_q[p*10 +: 10], 4'h0} > th_x[13:0])
                    phase_warn_r[p] <= 1'b1;
                else if (i_clear_faults)
                    phase_warn_r[p] <= 1'b0;
            end
        end
    endgenerate

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            temp_fault_r_flag <= 1'b0;
            temp_warn_r <= 1'b0;
        end
        else
        begin
            if (over_fault)
                temp_fault_r_flag <= 1'b1;
            else if (i_clear_faults && !(state_r == ocot_pkg::ST_WAIT_COOL && !below_release))
                temp_fault_r_flag <= 1'b0;
            if (warn_q != `OCOT_TEMP_OFF_Q && temp_q > warn_q)
                temp_warn_r <= 1'b1;
            else if (i_clear_faults)
                temp_warn_r <= 1'b0;
        end
    end

    assign o_phase_warning = phase_warn_r;
    assign o_current_warning_flag = |phase_warn_r;
    assign o_status_byte_nota = |phase_warn_r;
    assign o_status_word_iout = |phase_warn_r;
    assign o_temp_fault_flag = temp_fault_r_flag;
    assign o_temp_warning_flag = temp_warn_r;
    assign o_status_byte_temp = temp_fault_r_flag | temp_warn_r;
    assign o_unsupported_data = bad_data_r;
    assign o_notify = o_status_byte_temp | (|phase_warn_r) | bad_data_r;
    // 1/64 A internal grid down to 0.25 A steps
    assign o_cur_threshold_q = th_x[11:4];

    // 1 ms enable for all shutdown and hiccup timing
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n || tick_cnt_r == 16'(MS_CYCLES - 1))
            tick_cnt_r <= 16'h0000;
        else
            tick_cnt_r <= tick_cnt_r + 16'h0001;
    end
    assign ms_tick = tick_cnt_r == 16'(MS_CYCLES - 1);

    assign delay_ms = (delay_sel == 3'd0) ? 12'(`OCOT_DELAY0_MS) : {9'h000, delay_sel};
    // hiccup multiplier: 0 gives 1x, 1-3 give 2x, 4-6 give 3x, 7 gives 4x
    assign hiccup_ms = (delay_sel == 3'd0) ? {4'h0, i_ton_rise_ms} :
                       12'(i_ton_rise_ms * (3'd2 + 3'((delay_sel - 3'd1) / 3'd3)));
    assign give_up = (policy == 3'd0) ||
                     (policy != `OCOT_POLICY_FOREVER && attempts_r >= policy);

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            state_r <= ocot_pkg::ST_RUN;
            timer_r <= 12'h000;
            attempts_r <= 3'd0;
            restart_r <= 1'b0;
        end
        else
        begin
            restart_r <= 1'b0;
            if (ms_tick && timer_r != 12'h000)
                timer_r <= timer_r - 12'h001;
            if (!i_output_enable)
            begin
                state_r <= ocot_pkg::ST_RUN;
                attempts_r <= 3'd0;
            end
            else
            begin
                case (state_r)
                    ocot_pkg::ST_RUN:
                    begin
                        if (i_startup_ok)
                            attempts_r <= 3'd0;
                        if (over_fault)
                        begin
                            case (act_sel)
                                `OCOT_ACT_DELAYED:
                                begin
                                    state_r <= ocot_pkg::ST_DELAY;
                                    timer_r <= delay_ms;
                                end
                                `OCOT_ACT_IMMEDIATE:
                                begin
                                    state_r <= give_up ? ocot_pkg::ST_LATCHED : ocot_pkg::ST_HICCUP;
                                    timer_r <= hiccup_ms;
                                end
                                `OCOT_ACT_WAIT_COOL:
                                    state_r <= ocot_pkg::ST_WAIT_COOL;
                                default:
                                    ;
                            endcase
                        end
                    end
                    ocot_pkg::ST_DELAY:
                    begin
                        if (!over_fault)
                            state_r <= ocot_pkg::ST_RUN;
                        else if (timer_r == 12'h000)
                        begin
                            state_r <= give_up ? ocot_pkg::ST_LATCHED : ocot_pkg::ST_HICCUP;
                            timer_r <= hiccup_ms;
                        end
                    end
                    ocot_pkg::ST_WAIT_COOL:
                    begin
                        if (below_release)
                        begin
                            state_r <= (policy == 3'd0) ? ocot_pkg::ST_LATCHED : ocot_pkg::ST_RUN;
                            restart_r <= policy != 3'd0;
                        end
                    end
                    ocot_pkg::ST_HICCUP:
                    begin
                        if (timer_r == 12'h000)
                        begin
                            // attempts made while still hot are counted too
                            if (attempts_r != 3'd7)
                                attempts_r <= attempts_r + 3'd1;
                            if (below_release)
                            begin
                                state_r <= ocot_pkg::ST_RUN;
                                restart_r <= 1'b1;
                            end
                            else if (policy != `OCOT_POLICY_FOREVER && attempts_r + 3'd1 >= policy)
                                state_r <= ocot_pkg::ST_LATCHED;
                            else
                                timer_r <= hiccup_ms;
                        end
                    end
                    ocot_pkg::ST_LATCHED:
                        ;
                    default:
                        state_r <= ocot_pkg::ST_RUN;
                endcase
            end
        end
    end

    assign o_restart = restart_r;
    assign o_latched_off = state_r == ocot_pkg::ST_LATCHED;
    assign o_shutdown = state_r == ocot_pkg::ST_WAIT_COOL || state_r == ocot_pkg::ST_HICCUP ||
                        state_r == ocot_pkg::ST_LATCHED;

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    phase_warn_set_a: assert property (
        {i_phase_current_q[9:0], 4'h0} > th_x[13:0] && !i_clear_faults |=> o_phase_warning[0])
        else $error("phase 0 warning not set");
    iout_status_a: assert property (
        $rose(o_phase_warning[0]) |-> o_status_word_iout && o_status_byte_nota && o_notify)
        else $error("iout status bits missing");
    cur_exp_reset_a: assert property (disable iff (1'b0)
        !i_rst_n |=> cur_warn_r[15:11] == `OCOT_CUR_EXP_RST)
        else $error("current exponent reset wrong");
    bad_write_a: assert property (
        wr_strobe && !i_nvm_restore && i_cmd_code == `OCOT_CMD_CUR_WARN &&
        (wr_cur_x < 0 || wr_cur_x > `OCOT_CUR_MAX_X * `OCOT_PHASES)
        |=> o_unsupported_data && cur_warn_r == $past(cur_warn_r))
        else $error("bad write not refused");
    threshold_step_a: assert property (
        th_x >= `OCOT_CUR_MIN_X && th_x <= `OCOT_CUR_MAX_X && th_x[6:0] == 7'h00 && th_x >= per_x[13:0]
        || per_x > `OCOT_CUR_MAX_X)
        else $error("threshold off the 2 A grid");
    restore_round_a: assert property (
        i_nvm_restore |=> cur_warn_r[15:11] == `OCOT_CUR_EXP_RST && temp_fault_r[15:11] == 5'b00000
        && temp_fault_r[10:0] <= 11'd160)
        else $error("restore did not round");
    ot_disabled_a: assert property (
        fault_q == `OCOT_TEMP_OFF_Q |-> !over_fault)
        else $error("255 C did not disable fault");
    temp_fault_a: assert property (
        over_fault |=> o_temp_fault_flag && o_status_byte_temp && o_notify)
        else $error("temperature fault not flagged");
    immediate_off_a: assert property (
        state_r == ocot_pkg::ST_RUN && i_output_enable && over_fault && act_sel == `OCOT_ACT_IMMEDIATE
        |=> o_shutdown)
        else $error("immediate shutdown missed");
    restart_cool_a: assert property (
        o_restart |-> $past(below_release))
        else $error("restart while hot");
    clear_hold_a: assert property (
        state_r == ocot_pkg::ST_WAIT_COOL && o_temp_fault_flag && !below_release && i_output_enable
        |=> o_temp_fault_flag)
        else $error("fault cleared while hot");

    cover_delayed_c: cover property (state_r == ocot_pkg::ST_DELAY ##1 state_r == ocot_pkg::ST_HICCUP);
    cover_restart_c: cover property (state_r == ocot_pkg::ST_HICCUP ##1 o_restart);
    cover_latch_c: cover property (state_r == ocot_pkg::ST_HICCUP ##1 state_r == ocot_pkg::ST_LATCHED);
endmodule

// file: test/ocot_host_model.sv
`timescale 1ns/10ps
module ocot_host_model (
    input wire logic i_clock, // bus clock
    input wire logic i_rdata_valid, // read strobe back
    input wire logic [15:0] i_rdata, // read data back
    output logic o_cmd_valid, // command strobe
    output logic o_cmd_write, // 1 write, 0 read
    output logic [7:0] o_cmd_code, // command code
    output logic [15:0] o_cmd_wdata // write word
);
    initial
    begin
        o_cmd_valid = 1'b0;
        o_cmd_write = 1'b0;
        o_cmd_code = 8'h00;
        o_cmd_wdata = 16'hffff;
    end
    // whole 16-bit linear word, exponent in 15:11, one strobe per command
    task automatic write_cmd(input logic [7:0] code, input logic [15:0] data);
        @(negedge i_clock);
        o_cmd_valid = 1'b1;
        o_cmd_write = 1'b1;
        o_cmd_code = code;
        o_cmd_wdata = data;
        @(negedge i_clock);
        o_cmd_valid = 1'b0;
        // released data must not look like the last word
        o_cmd_wdata = ~data;
    endtask
    task automatic read_cmd(input logic [7:0] code, output logic [15:0] data, output logic ok);
        @(negedge i_clock);
        o_cmd_valid = 1'b1;
        o_cmd_write = 1'b0;
        o_cmd_code = code;
        @(negedge i_clock);
        o_cmd_valid = 1'b0;
        ok = i_rdata_valid;
        data = i_rdata;
    endtask
endmodule

// file: test/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    logic i_clock, i_rst_n, i_nvm_restore, i_clear_faults, i_output_enable, i_startup_ok;
    logic [7:0] i_ton_rise_ms;
    logic signed [11:0] i_temp_q, i_warn_limit_q;
    logic [39:0] i_phase_current_q;
    logic cmd_valid, cmd_write, rdata_valid, nota, word_iout, cur_warn, byte_temp;
    logic temp_fault, temp_warn, unsupported, notify, shutdown, restart, latched_off;
    logic [7:0] cmd_code, cur_thr;
    logic [15:0] cmd_wdata, rdata;
    logic [3:0] phase_warn;
    int num_errors = 0;
    int n_tests = 0;
    int n;

    ocot_monitor #(.MS_CYCLES(20)) ocot_monitor_i (
        .i_clock(i_clock), .i_rst_n(i_rst_n), .i_cmd_valid(cmd_valid), .i_cmd_write(cmd_write),
        .i_cmd_code(cmd_code), .i_cmd_wdata(cmd_wdata), .i_nvm_restore(i_nvm_restore),
        .i_clear_faults(i_clear_faults), .i_output_enable(i_output_enable), .i_startup_ok(i_startup_ok),
        .i_ton_rise_ms(i_ton_rise_ms), .i_temp_q(i_temp_q), .i_warn_limit_q(i_warn_limit_q),
        .i_phase_current_q(i_phase_current_q), .o_rdata(rdata), .o_rdata_valid(rdata_valid),
        .o_phase_warning(phase_warn), .o_current_warning_flag(cur_warn), .o_status_byte_nota(nota),
        .o_status_word_iout(word_iout), .o_status_byte_temp(byte_temp), .o_temp_fault_flag(temp_fault),
        .o_temp_warning_flag(temp_warn), .o_unsupported_data(unsupported), .o_notify(notify),
        .o_cur_threshold_q(cur_thr), .o_shutdown(shutdown), .o_restart(restart), .o_latched_off(latched_off));

    ocot_host_model ocot_host_model_i (
        .i_clock(i_clock), .i_rdata_valid(rdata_valid), .i_rdata(rdata), .o_cmd_valid(cmd_valid),
        .o_cmd_write(cmd_write), .o_cmd_code(cmd_code), .o_cmd_wdata(cmd_wdata));

    initial
    begin
        i_clock = 1'b0;
        forever #20 i_clock = ~i_clock;
    end

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge i_clock);
    endtask
    task automatic wr(input logic [7:0] code, input logic [15:0] data);
        ocot_host_model_i.write_cmd(code, data);
        cyc(1);
    endtask
    task automatic rd(input logic [7:0] code, input logic [15:0] exp);
        logic [15:0] d;
        logic ok;
        ocot_host_model_i.read_cmd(code, d, ok);
        chk({15'h0000, ok}, 16'h0001);
        chk(d, exp);
    endtask
    task automatic clear_pulse;
        i_clear_faults = 1'b1;
        cyc(1);
        i_clear_faults = 1'b0;
        cyc(2);
    endtask
    task automatic restore_pulse;
        i_nvm_restore = 1'b1;
        cyc(1);
        i_nvm_restore = 1'b0;
        cyc(2);
    endtask
    // cycles until a visible restart, or hi if none came
    task automatic wait_restart(input int hi, output int k);
        k = 0;
        while (restart !== 1'b1 && k < hi)
        begin
            cyc(1);
            k++;
        end
    endtask
    // cool down, cycle the output enable and clear all sticky flags
    task automatic quiet;
        i_temp_q = 12'h12c;
        i_warn_limit_q = 12'h168;
        i_phase_current_q = {4{10'h014}};
        i_output_enable = 1'b0;
        cyc(2);
        i_output_enable = 1'b1;
        clear_pulse();
    endtask

    task automatic t_reset;
        rd(8'h4a, 16'hf3e0);
        rd(8'h4f, 16'h007d);
        rd(8'h50, 16'h0080);
        chk({8'h00, cur_thr}, 16'h00f8);
        chk({14'h0000, shutdown, notify}, 16'h0000);
    endtask
    task automatic t_cur_limit;
        wr(8'h4a, 16'hf190);
        chk({8'h00, cur_thr}, 16'h0068);
        wr(8'h4a, 16'hf050);
        chk({8'h00, cur_thr}, 16'h0020);
        rd(8'h4a, 16'hf050);
        wr(8'h4a, 16'hf3e8);
        chk({15'h0000, unsupported}, 16'h0001);
        chk({15'h0000, notify}, 16'h0001);
        chk({8'h00, cur_thr}, 16'h0020);
        rd(8'h4a, 16'hf050);
        quiet();
    endtask
    task automatic t_phase_warn;
        i_phase_current_q = {10'h014, 10'h03c, 10'h014, 10'h014};
        cyc(3);
        chk({12'h000, phase_warn}, 16'h0004);
        chk({12'h000, cur_warn, nota, word_iout, notify}, 16'h000f);
        quiet();
        chk({11'h000, phase_warn, notify}, 16'h0000);
    endtask
    task automatic t_restore;
        wr(8'h4a, 16'he321);
        restore_pulse();
        rd(8'h4a, 16'hf0c8);
        wr(8'h4f, 16'h00c8);
        restore_pulse();
        rd(8'h4f, 16'h00a0);
    endtask
    task automatic t_immediate;
        wr(8'h4f, 16'h0064);
        wr(8'h50, 16'h0080);
        i_temp_q = 12'h194;
        cyc(3);
        chk({12'h000, temp_fault, byte_temp, temp_warn, notify}, 16'h000f);
        chk({14'h0000, shutdown, latched_off}, 16'h0003);
        quiet();
        chk({13'h0000, shutdown, temp_fault, notify}, 16'h0000);
    endtask
    task automatic t_ignore_and_off;
        wr(8'h50, 16'h0000);
        i_temp_q = 12'h194;
        cyc(40);
        chk({14'h0000, temp_fault, shutdown}, 16'h0002);
        quiet();
        wr(8'h4f, 16'h00ff);
        wr(8'h50, 16'h0080);
        i_warn_limit_q = 12'h3fc;
        i_temp_q = 12'h320;
        cyc(10);
        chk({14'h0000, temp_fault, shutdown}, 16'h0000);
        quiet();
        wr(8'h4f, 16'h0064);
    endtask
    task automatic t_delayed;
        wr(8'h50, 16'h0043);
        i_temp_q = 12'h194;
        cyc(20);
        chk({15'h0000, shutdown}, 16'h0000);
        cyc(60);
        chk({14'h0000, shutdown, latched_off}, 16'h0003);
        quiet();
    endtask
    task automatic t_hiccup;
        wr(8'h50, 16'h0090);
        i_temp_q = 12'h194;
        cyc(3);
        chk({14'h0000, shutdown, latched_off}, 16'h0002);
        wait_restart(120, n);
        chk(16'(n), 16'h0078);
        chk({15'h0000, latched_off}, 16'h0001);
        quiet();
        i_ton_rise_ms = 8'h02;
        wr(8'h50, 16'h0097);
        i_temp_q = 12'h194;
        cyc(2);
        chk({15'h0000, shutdown}, 16'h0001);
        i_temp_q = 12'h12c;
        wait_restart(250, n);
        // hiccup is 4 x 2 ms, 160 cycles, accepted window 130 to 200 cycles
        chk({15'h0000, 1'(n >= 130 && n <= 200)}, 16'h0001);
        cyc(1);
        chk({15'h0000, shutdown}, 16'h0000);
        i_ton_rise_ms = 8'h01;
        quiet();
    endtask
    // policy 7 keeps retrying while hot and never latches
    task automatic t_forever;
        wr(8'h50, 16'h00b8);
        i_temp_q = 12'h194;
        cyc(120);
        chk({14'h0000, shutdown, latched_off}, 16'h0002);
        quiet();
    endtask
    task automatic t_wait_cool;
        wr(8'h50, 16'h00c8);
        i_warn_limit_q = 12'h3fc;
        i_temp_q = 12'h194;
        cyc(3);
        chk({15'h0000, shutdown}, 16'h0001);
        i_temp_q = 12'h154;
        clear_pulse();
        chk({14'h0000, temp_fault, shutdown}, 16'h0003);
        i_temp_q = 12'h13c;
        wait_restart(5, n);
        chk({15'h0000, restart}, 16'h0001);
        cyc(1);
        chk({15'h0000, shutdown}, 16'h0000);
        quiet();
    endtask

    initial
    begin
        i_rst_n = 1'b0;
        i_nvm_restore = 1'b0;
        i_clear_faults = 1'b0;
        i_output_enable = 1'b1;
        i_startup_ok = 1'b0;
        i_ton_rise_ms = 8'h01;
        i_temp_q = 12'h12c;
        i_warn_limit_q = 12'h168;
        i_phase_current_q = {4{10'h014}};
        repeat (12) @(negedge i_clock);
        i_rst_n = 1'b1;
        t_reset();
        t_cur_limit();
        t_phase_warn();
        t_restore();
        t_immediate();
        t_ignore_and_off();
        t_delayed();
        t_hiccup();
        t_forever();
        t_wait_cool();
        give_verdict();
    end

    // the whole sequence needs about 700 cycles
    initial
    begin
        repeat (20000) @(posedge i_clock);
        num_errors++;
        give_verdict();
    end
endmodule
